//--- core/ltm_level_trim_and_irq_mask_regs.sv
`timescale 1ns/1ps
module ltm_level_trim_and_irq_mask_regs (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        reg_write_strobe,
    input  wire logic [7:0]  reg_address,
    input  wire logic [15:0] reg_write_data,
    input  wire logic        prog_word_tone_level_write,
    input  wire logic        prog_word_output_a_trim_write,
    input  wire logic        prog_word_output_b_trim_write,
    input  wire logic        prog_word_subaudio_level_write,
    input  wire logic [11:0] prog_word_data,
    input  wire logic        rx_mode,
    input  wire logic        voice_path_enable,
    input  wire logic [3:0]  coarse_output_gain,
    input  wire logic        keypad_tone_detect,
    input  wire logic        aux_converter_a_event,
    input  wire logic        aux_converter_b_event,
    input  wire logic        modem_tx_end,
    input  wire logic        modem_data_request,
    input  wire logic        block_checksum_error,
    input  wire logic        fast_baud_detect,
    input  wire logic        slow_baud_detect,
    input  wire logic        program_ready_flag,
    input  wire logic        status_read_strobe,
    output logic [11:0]      tone_level_gain,
    output logic [11:0]      rx_voice_gain,
    output logic [15:0]      total_volume,
    output logic [11:0]      output_a_trim,
    output logic [11:0]      output_b_trim,
    output logic [2:0]       tx_voice_shift,
    output logic [3:0]       modulator_out_a_atten,
    output logic [3:0]       modulator_out_b_atten,
    output logic [11:0]      subaudio_tx_gain,
    output logic [15:0]      interrupt_pending,
    output logic             host_interrupt_out_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Out-of-range codes clamp to the deepest documented step
    function automatic logic [3:0] clamp_atten(input logic [3:0] code);
        clamp_atten = (code > ltm_pkg::MAX_MOD_ATTEN) ?
                      ltm_pkg::MAX_MOD_ATTEN : code;
    endfunction

    // Selector match, gated by a write to the level register
    function automatic logic sel_is(input logic       wr,
                                    input logic [3:0] sel,
                                    input logic [3:0] code);
        sel_is = wr && sel == code;
    endfunction

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic [3:0]  write_selector;
    logic [11:0] write_value;
    logic        level_write;
    logic        mask_write;
    logic        sel_tone;
    logic        sel_rx_voice;
    logic        sel_out_a;
    logic        sel_out_b;
    logic        sel_tx_mult;
    logic        sel_mod;
    logic        sel_subaudio;
    logic [2:0]  mult_code;
    logic [3:0]  atten_a_code;
    logic [3:0]  atten_b_code;

    assign write_selector = reg_write_data[ltm_pkg::SEL_MSB:ltm_pkg::SEL_LSB];
    assign write_value    = reg_write_data[ltm_pkg::VAL_MSB:0];
    // Test slot and other addresses fall through undecoded
    assign level_write  = reg_write_strobe &&
                          reg_address == ltm_pkg::ADDR_LEVEL_TRIM_SELECT;
    assign mask_write   = reg_write_strobe &&
                          reg_address == ltm_pkg::ADDR_INTERRUPT_ENABLE_MASK;

    // Reserved selectors match nothing and leave every level alone
    assign sel_tone     = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_TONE_LEVEL);
    assign sel_rx_voice = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_RX_VOICE);
    assign sel_out_a    = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_OUT_A_TRIM);
    assign sel_out_b    = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_OUT_B_TRIM);
    assign sel_tx_mult  = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_TX_MULT);
    assign sel_mod      = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_MOD_ATTEN);
    assign sel_subaudio = sel_is(level_write, write_selector,
                                 ltm_pkg::SEL_SUBAUDIO);

    // Upper bits ignored; host keeps them zero
    assign mult_code    = write_value[ltm_pkg::MULT_MSB:0];
    assign atten_a_code = write_value[ltm_pkg::MOD_A_MSB:ltm_pkg::MOD_A_LSB];
    assign atten_b_code = write_value[ltm_pkg::MOD_B_MSB:ltm_pkg::MOD_B_LSB];

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    logic        load_tone;
    logic        load_out_a;
    logic        load_out_b;
    logic        load_subaudio;
    logic [11:0] next_tone_level;
    logic [11:0] next_output_a_trim;
    logic [11:0] next_output_b_trim;
    logic [11:0] next_subaudio_gain;
    logic [2:0]  next_tx_shift;
    logic [3:0]  next_atten_a;
    logic [3:0]  next_atten_b;

    // Either source may load; the one written last stays
    assign load_tone     = sel_tone || prog_word_tone_level_write;
    assign load_out_a    = sel_out_a || prog_word_output_a_trim_write;
    assign load_out_b    = sel_out_b || prog_word_output_b_trim_write;
    assign load_subaudio = sel_subaudio || prog_word_subaudio_level_write;

    // Register write wins a same-cycle collision with a program word
    assign next_tone_level    = sel_tone ? write_value : prog_word_data;
    assign next_output_a_trim = sel_out_a ? write_value : prog_word_data;
    assign next_output_b_trim = sel_out_b ? write_value : prog_word_data;
    assign next_subaudio_gain = sel_subaudio ? write_value : prog_word_data;

    // Beyond x32 the multiplier would overflow, so hold at x32
    assign next_tx_shift = (mult_code > ltm_pkg::MAX_TX_MULT) ?
                           ltm_pkg::MAX_TX_MULT : mult_code;
    assign next_atten_a  = clamp_atten(atten_a_code);
    assign next_atten_b  = clamp_atten(atten_b_code);

    // ------------------------------------------------------------
    // Level state
    // ------------------------------------------------------------
    logic [11:0] rx_voice_level;
    logic [15:0] interrupt_mask;

    // Shadowed levels stay live; no return to idle needed
    always_ff @(posedge clock) begin
        if (reset) begin
            tone_level_gain <= ltm_pkg::RESET_UNITY_GAIN;
        end else if (load_tone) begin
            tone_level_gain <= next_tone_level;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            output_a_trim <= ltm_pkg::RESET_UNITY_GAIN;
        end else if (load_out_a) begin
            output_a_trim <= next_output_a_trim;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            output_b_trim <= ltm_pkg::RESET_UNITY_GAIN;
        end else if (load_out_b) begin
            output_b_trim <= next_output_b_trim;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            subaudio_tx_gain <= ltm_pkg::RESET_UNITY_GAIN;
        end else if (load_subaudio) begin
            subaudio_tx_gain <= next_subaudio_gain;
        end
    end

    // Codes pass through unchanged; FFF is unity, ~0.2 dB per step
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_voice_level <= ltm_pkg::RESET_UNITY_GAIN;
        end else if (sel_rx_voice) begin
            rx_voice_level <= write_value;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_voice_shift <= ltm_pkg::RESET_TX_MULT;
        end else if (sel_tx_mult) begin
            tx_voice_shift <= next_tx_shift;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            modulator_out_a_atten <= ltm_pkg::RESET_MOD_ATTEN;
            modulator_out_b_atten <= ltm_pkg::RESET_MOD_ATTEN;
        end else if (sel_mod) begin
            modulator_out_a_atten <= next_atten_a;
            modulator_out_b_atten <= next_atten_b;
        end
    end

    // ------------------------------------------------------------
    // Receive voice path
    // ------------------------------------------------------------
    logic        rx_scaling_active;
    logic [11:0] next_rx_voice_gain;

    assign rx_scaling_active  = rx_mode && voice_path_enable;
    assign next_rx_voice_gain = rx_scaling_active ? rx_voice_level
                                                  : ltm_pkg::RESET_UNITY_GAIN;

    // Live update, no idle needed
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_voice_gain <= ltm_pkg::RESET_UNITY_GAIN;
            total_volume  <= {4'h0, ltm_pkg::RESET_UNITY_GAIN};
        end else begin
            rx_voice_gain <= next_rx_voice_gain;
            total_volume  <= {coarse_output_gain, next_rx_voice_gain};
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and pending events
    // ------------------------------------------------------------
    logic        aux_a_last;
    logic        aux_b_last;
    logic        prog_ready_last;
    logic [15:0] raw_events;
    logic [15:0] next_pending;
    logic        next_irq_active;

    always_ff @(posedge clock) begin
        if (reset) begin
            interrupt_mask <= ltm_pkg::RESET_MASK;
        end else if (mask_write) begin
            interrupt_mask <= reg_write_data & ltm_pkg::MASK_WRITABLE;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            aux_a_last      <= 1'b0;
            aux_b_last      <= 1'b0;
            prog_ready_last <= 1'b0;
        end else begin
            aux_a_last      <= aux_converter_a_event;
            aux_b_last      <= aux_converter_b_event;
            prog_ready_last <= program_ready_flag;
        end
    end

    always_comb begin
        raw_events = 16'h0000;
        raw_events[ltm_pkg::SRC_KEYPAD]    = keypad_tone_detect;
        raw_events[ltm_pkg::SRC_AUX_B]     =
            aux_converter_b_event ^ aux_b_last;
        raw_events[ltm_pkg::SRC_AUX_A]     =
            aux_converter_a_event ^ aux_a_last;
        raw_events[ltm_pkg::SRC_TX_END]    = modem_tx_end;
        raw_events[ltm_pkg::SRC_DATA_REQ]  = modem_data_request;
        raw_events[ltm_pkg::SRC_CRC_ERR]   = block_checksum_error;
        raw_events[ltm_pkg::SRC_FAST_BAUD] = fast_baud_detect;
        raw_events[ltm_pkg::SRC_SLOW_BAUD] = slow_baud_detect;
        raw_events[ltm_pkg::SRC_PROG_RDY]  =
            program_ready_flag & ~prog_ready_last;
    end

    // A fresh event outranks the status read that clears it
    assign next_pending = (status_read_strobe ? 16'h0000 : interrupt_pending)
                          | (raw_events & interrupt_mask);
    assign next_irq_active = interrupt_mask[ltm_pkg::MASK_MASTER] &&
                             |next_pending;

    always_ff @(posedge clock) begin
        if (reset) begin
            interrupt_pending    <= 16'h0000;
            host_interrupt_out_n <= 1'b1;
        end else begin
            interrupt_pending    <= next_pending;
            host_interrupt_out_n <= ~next_irq_active;
        end
    end

endmodule

//--- include/ltm_pkg.sv
package ltm_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_LEVEL_TRIM_SELECT     = 8'hcd;
    localparam logic [7:0]  ADDR_INTERRUPT_ENABLE_MASK = 8'hce;
    localparam logic [7:0]  ADDR_FACTORY_TEST_SLOT     = 8'hcf;

    // ------------------------------------------------------------
    // Selector field and codes
    // ------------------------------------------------------------
    localparam int          SEL_MSB = 15;
    localparam int          SEL_LSB = 12;
    localparam int          VAL_MSB = 11;
    localparam logic [3:0]  SEL_TONE_LEVEL   = 4'h2;
    localparam logic [3:0]  SEL_RX_VOICE     = 4'h4;
    localparam logic [3:0]  SEL_OUT_A_TRIM   = 4'h6;
    localparam logic [3:0]  SEL_OUT_B_TRIM   = 4'h8;
    localparam logic [3:0]  SEL_TX_MULT      = 4'ha;
    localparam logic [3:0]  SEL_MOD_ATTEN    = 4'hc;
    localparam logic [3:0]  SEL_SUBAUDIO     = 4'hd;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          MULT_MSB    = 2;
    localparam int          MOD_A_MSB   = 3;
    localparam int          MOD_A_LSB   = 0;
    localparam int          MOD_B_MSB   = 7;
    localparam int          MOD_B_LSB   = 4;
    localparam int          MASK_MASTER = 15;

    // ------------------------------------------------------------
    // Reset and limit values
    // ------------------------------------------------------------
    localparam logic [11:0] RESET_UNITY_GAIN = 12'hfff;
    localparam logic [2:0]  RESET_TX_MULT    = 3'h0;
    localparam logic [2:0]  MAX_TX_MULT      = 3'h5;
    localparam logic [3:0]  RESET_MOD_ATTEN  = 4'h0;
    localparam logic [3:0]  MAX_MOD_ATTEN    = 4'h9;
    localparam logic [15:0] RESET_MASK       = 16'h0000;
    // Bits 15 (master), 12, 9..3 and 0 are real enables; the rest read as zero
    localparam logic [15:0] MASK_WRITABLE    = 16'h93f9;

    // ------------------------------------------------------------
    // Interrupt source positions inside the mask
    // ------------------------------------------------------------
    localparam int          SRC_KEYPAD    = 12;
    localparam int          SRC_AUX_B     = 9;
    localparam int          SRC_AUX_A     = 8;
    localparam int          SRC_TX_END    = 7;
    localparam int          SRC_DATA_REQ  = 6;
    localparam int          SRC_CRC_ERR   = 5;
    localparam int          SRC_FAST_BAUD = 4;
    localparam int          SRC_SLOW_BAUD = 3;
    localparam int          SRC_PROG_RDY  = 0;
endpackage

//--- testbench/ltm_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host on the control bus
// ----------------------------------------
module ltm_host (
    input  wire logic   clock,
    output logic        reg_write_strobe = 1'b0,
    output logic [7:0]  reg_address = 8'h00,
    output logic [15:0] reg_write_data = 16'h0000,
    output logic        status_read_strobe = 1'b0
);
    // Released bus shows junk, not the last word
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        if (a != 8'hcf) begin
            reg_address = a;
            reg_write_data = d;
            reg_write_strobe = 1'b1;
            @(negedge clock);
            reg_write_strobe = 1'b0;
            reg_address = ~a;
            reg_write_data = ~d;
        end
    endtask
    task automatic rd();
        @(negedge clock);
        status_read_strobe = 1'b1;
        @(negedge clock);
        status_read_strobe = 1'b0;
    endtask
endmodule

//--- testbench/ltm_level_trim_and_irq_mask_regs_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ltm_chk (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        reg_write_strobe,
    input wire logic [7:0]  reg_address,
    input wire logic [15:0] reg_write_data,
    input wire logic        keypad_tone_detect,
    input wire logic        program_ready_flag,
    input wire logic [11:0] output_a_trim,
    input wire logic [11:0] subaudio_tx_gain,
    input wire logic [2:0]  tx_voice_shift,
    input wire logic [3:0]  modulator_out_b_atten,
    input wire logic [15:0] interrupt_pending,
    input wire logic        host_interrupt_out_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Mask mirror: the mask cannot be read back
    logic [15:0] mask_q;
    wire logic       wr_lvl;
    wire logic [3:0] sel;
    assign wr_lvl = reg_write_strobe && reg_address == 8'hcd;
    assign sel = reg_write_data[15:12];
    always_ff @(posedge clock) begin
        if (reset)
            mask_q <= 16'h0000;
        else if (reg_write_strobe && reg_address == 8'hce)
            mask_q <= reg_write_data;
    end
    chk_out_a_load: assert property (wr_lvl && sel == 4'h6 |=>
        output_a_trim == $past(reg_write_data[11:0])) else $error("trim A");
    chk_sub_load: assert property (wr_lvl && sel == 4'hd |=>
        subaudio_tx_gain == $past(reg_write_data[11:0])) else $error("subaud");
    chk_mult_clamp: assert property (wr_lvl && sel == 4'ha |=>
        tx_voice_shift == ($past(reg_write_data[2:0]) > 3'h5 ? 3'h5 :
        $past(reg_write_data[2:0]))) else $error("multiplier code");
    chk_mod_b_clamp: assert property (wr_lvl && sel == 4'hc |=>
        modulator_out_b_atten == ($past(reg_write_data[7:4]) > 4'h9 ?
        4'h9 : $past(reg_write_data[7:4]))) else $error("mod B atten");
    chk_master_gate: assert property (!mask_q[15] |=>
        host_interrupt_out_n) else $error("pin low, master off");
    chk_prog_rise: assert property (mask_q[0] &&
        $rose(program_ready_flag) |=> interrupt_pending[0])
        else $error("ready event lost");
    chk_keypad_irq: assert property (mask_q[15] && mask_q[12] &&
        keypad_tone_detect |=> interrupt_pending[12] && !host_interrupt_out_n)
        else $error("keypad interrupt missing");
    chk_irq_cause: assert property (!host_interrupt_out_n |->
        interrupt_pending != 16'h0000) else $error("pin low, none pending");
    cover property (wr_lvl && sel == 4'h6);
    cover property ($fell(host_interrupt_out_n));
    cover property (mask_q[0] && $rose(program_ready_flag));
endmodule
bind ltm_level_trim_and_irq_mask_regs ltm_chk ltm_chk_inst (.*);

//--- testbench/ltm_level_trim_and_irq_mask_regs_tb.sv
`timescale 1ns/1ps
module ltm_level_trim_and_irq_mask_regs_tb;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        rx_mode = 1'b0;
    logic        voice_path_enable = 1'b0;
    logic [3:0]  coarse_output_gain = 4'h0;
    logic [11:0] prog_word_data = 12'h000;
    logic [3:0]  pw = 4'h0;
    logic [15:0] ev = 16'h0000;
    logic [15:0] m, d;
    logic [11:0] rg;
    wire         reg_write_strobe, status_read_strobe, host_interrupt_out_n;
    wire  [7:0]  reg_address;
    wire  [15:0] reg_write_data, total_volume, interrupt_pending;
    wire  [11:0] tone_level_gain, rx_voice_gain, output_a_trim;
    wire  [11:0] output_b_trim, subaudio_tx_gain;
    wire  [3:0]  modulator_out_a_atten, modulator_out_b_atten;
    wire  [2:0]  tx_voice_shift;
    wire         keypad_tone_detect, program_ready_flag, modem_tx_end;
    wire         prog_word_tone_level_write, prog_word_output_a_trim_write;
    wire         prog_word_output_b_trim_write, prog_word_subaudio_level_write;
    wire         aux_converter_a_event, aux_converter_b_event;
    wire         modem_data_request, block_checksum_error;
    wire         fast_baud_detect, slow_baud_detect;
    int          n_errors = 0, cmp_count = 0, i;
    int          srcs[9] = '{12, 9, 8, 7, 6, 5, 4, 3, 0};
    int          t_tone = 12'hfff, t_rx = 12'hfff, t_a = 12'hfff;
    int          t_b = 12'hfff, t_sub = 12'hfff, t_sh = 0, t_ma = 0, t_mb = 0;
    assign {prog_word_subaudio_level_write, prog_word_output_b_trim_write,
            prog_word_output_a_trim_write, prog_word_tone_level_write} = pw;
    assign {aux_converter_b_event, aux_converter_a_event, modem_tx_end,
            modem_data_request, block_checksum_error, fast_baud_detect,
            slow_baud_detect} = ev[9:3];
    assign keypad_tone_detect = ev[12];
    assign program_ready_flag = ev[0];
    ltm_level_trim_and_irq_mask_regs
        ltm_level_trim_and_irq_mask_regs_inst (.*);
    ltm_host ltm_host_inst (.*);
    initial forever #5 clock = ~clock;
    task automatic cmp(string s, logic [95:0] got, logic [95:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("Compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Model of the level register; reserved selectors change nothing
    task automatic upd(logic [15:0] w);
        case (w[15:12])
            4'h2: t_tone = w[11:0];
            4'h4: t_rx = w[11:0];
            4'h6: t_a = w[11:0];
            4'h8: t_b = w[11:0];
            4'hd: t_sub = w[11:0];
            4'ha: t_sh = (w[2:0] > 3'h5) ? 5 : w[2:0];
            4'hc: begin
                t_ma = (w[3:0] > 4'h9) ? 9 : w[3:0];
                t_mb = (w[7:4] > 4'h9) ? 9 : w[7:4];
            end
            default: ;
        endcase
    endtask
    task automatic chk_lvl();
        rg = (rx_mode && voice_path_enable) ? t_rx[11:0] : 12'hfff;
        cmp("levels", {9'h000, tone_level_gain, rx_voice_gain, output_a_trim,
            output_b_trim, subaudio_tx_gain, total_volume, tx_voice_shift,
            modulator_out_a_atten, modulator_out_b_atten},
            {9'h000, t_tone[11:0], rg, t_a[11:0], t_b[11:0], t_sub[11:0],
            coarse_output_gain, rg, t_sh[2:0], t_ma[3:0], t_mb[3:0]});
    endtask
    task automatic chk_irq(logic [15:0] p, logic n);
        cmp("irq", {79'h0, interrupt_pending, host_interrupt_out_n},
            {79'h0, p, n});
    endtask
    initial begin
        void'($urandom(32'hea70));
        repeat (3) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        chk_lvl();
        repeat (40) begin
            d = {4'($urandom), 12'($urandom)};
            if (d[15:12] == 4'ha) d[11:3] = 9'h000;
            if (d[15:12] == 4'hc) d[11:8] = 4'h0;
            {rx_mode, voice_path_enable} = 2'($urandom);
            coarse_output_gain = 4'($urandom);
            if ($urandom % 6 == 0) begin
                ltm_host_inst.wr(8'h10, d);
            end else begin
                ltm_host_inst.wr(8'hcd, d);
                upd(d);
            end
            @(negedge clock);
            chk_lvl();
        end
        for (int j = 0; j < 4; j++) begin
            @(negedge clock);
            pw[j] = 1'b1;
            prog_word_data = 12'($urandom);
            @(negedge clock);
            pw = 4'h0;
            upd({4'(16'hd862 >> (4 * j)), prog_word_data});
            chk_lvl();
        end
        // Same edge: the bus write must beat the program word
        fork
            ltm_host_inst.wr(8'hcd, 16'h6abc);
            begin
                @(negedge clock);
                pw[1] = 1'b1;
                @(negedge clock);
                pw[1] = 1'b0;
            end
        join
        upd(16'h6abc);
        @(negedge clock);
        chk_lvl();
        for (int s = 0; s < 18; s++) begin
            i = srcs[s / 2];
            m = 16'($urandom) & 16'h93f9;
            if (s % 2 == 0) m = m | 16'h8000 | (16'h0001 << i);
            ltm_host_inst.wr(8'hce, m);
            ev[i] = (i == 8 || i == 9) ? ~ev[i] : 1'b1;
            @(negedge clock);
            d = 16'(m[i]) << i;
            chk_irq(d, ~(m[15] & m[i]));
            ev = ev & 16'h0300;
            ltm_host_inst.rd();
            chk_irq(16'h0000, 1'b1);
        end
        // Reset in mid-run must drop the mask and every level
        ltm_host_inst.wr(8'hce, 16'h9000);
        ltm_host_inst.wr(8'hcd, 16'h6123);
        ev[12] = 1'b1;
        @(negedge clock);
        chk_irq(16'h1000, 1'b0);
        ev[12] = 1'b0;
        coarse_output_gain = 4'h0;
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        t_tone = 12'hfff;
        t_rx = 12'hfff;
        t_a = 12'hfff;
        t_b = 12'hfff;
        t_sub = 12'hfff;
        t_sh = 0;
        t_ma = 0;
        t_mb = 0;
        chk_lvl();
        chk_irq(16'h0000, 1'b1);
        ev[12] = 1'b1;
        @(negedge clock);
        ev[12] = 1'b0;
        @(negedge clock);
        chk_irq(16'h0000, 1'b1);
        end_sim();
    end
    initial begin
        #20000;
        n_errors++;
        end_sim();
    end
endmodule
